// ---- inc/caio_pkg.sv ----
package caio_pkg;
  // ---------------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    CAIO_OP_NOP     = 4'h0,
    CAIO_OP_ADD     = 4'h1,
    CAIO_OP_ADC     = 4'h2,
    CAIO_OP_SUB     = 4'h3,
    CAIO_OP_SUBC    = 4'h4,
    CAIO_OP_AND     = 4'h5,
    CAIO_OP_OR      = 4'h6,
    CAIO_OP_WADD    = 4'h7,
    CAIO_OP_WSUB    = 4'h8,
    CAIO_OP_IO_IN   = 4'h9,
    CAIO_OP_IO_OUT  = 4'hA,
    CAIO_OP_BIT_SET = 4'hB,
    CAIO_OP_BIT_CLR = 4'hC,
    CAIO_OP_SKIP_S  = 4'hD,
    CAIO_OP_SKIP_C  = 4'hE,
    CAIO_OP_LDST    = 4'hF
  } caio_op_e;

  // ---------------------------------------------------------------------
  // Flag positions in the status byte
  // ---------------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ---------------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------------
  localparam logic [8:0] IO_BIT_LAST  = 9'h01F;
  localparam logic [8:0] IO_LAST      = 9'h03F;
  localparam logic [8:0] IO_DATA_OFS  = 9'h020;
  localparam logic [8:0] EXT_IO_FIRST = 9'h060;
  localparam logic [8:0] EXT_IO_LAST  = 9'h1FF;

  // Cycle counts
  localparam int BYTE_OP_CYCLES = 1;
  localparam int WORD_OP_CYCLES = 2;
endpackage : caio_pkg

// ---- core/caio_alu.sv ----
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Contract
// - Add two bytes, optional carry in, one cycle, flags Z C N V H.
// - Add immediate to word pair in two cycles, flags Z C N V S.
// - Subtract register or constant in one cycle, flags Z C N V H.
// - Subtract with carry, register or constant, one cycle, Z C N V H.
// - Subtract immediate from word pair in two cycles, flags Z C N V S.
// - AND with register or constant, one cycle, only Z N V.
// - OR with register or constant, one cycle, only Z N V.
// - Bit set and clear only on I/O addresses 0x00 to 0x1F.
// - Skip on bit set or clear tests I/O bit in same range.
// - Bit set and clear are full read-modify-write of the register.
// - I/O in and out reach only the 64 locations from zero.
// - Load and store see each I/O register at its address plus 0x20.
// - Extended I/O 0x60 to 0x1FF reachable only by load and store.
module caio_alu #(
  parameter int DW = 8
) (
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic          op_valid_in,
  input  wire logic [3:0]    op_code_in,
  input  wire logic [DW-1:0] op_a_in,
  input  wire logic [DW-1:0] op_b_in,
  input  wire logic [DW-1:0] op_a_hi_in,
  input  wire logic [5:0]    word_imm_in,
  input  wire logic [8:0]    addr_in,
  input  wire logic [2:0]    bit_sel_in,
  input  wire logic [DW-1:0] io_rdata_in,
  output logic               op_ready_out,
  output logic               res_valid_out,
  output logic [DW-1:0]      res_lo_out,
  output logic [DW-1:0]      res_hi_out,
  output logic [7:0]         flags_out,
  output logic               skip_out,
  output logic               io_rd_out,
  output logic               io_wr_out,
  output logic [8:0]         io_addr_out,
  output logic [DW-1:0]      io_wdata_out,
  output logic               addr_err_out
);

  // -----------------------------------------------------------------------
  // Decode helpers
  // -----------------------------------------------------------------------
  // Bit-accessible range check, used by bit ops and skips
  function automatic logic in_bit_range(input logic [8:0] a);
    in_bit_range = (a <= caio_pkg::IO_BIT_LAST);
  endfunction : in_bit_range

  // Short I/O range check, six address bits only
  function automatic logic in_io_range(input logic [8:0] a);
    in_io_range = (a <= caio_pkg::IO_LAST);
  endfunction : in_io_range

  typedef enum logic [1:0] {
    CAIO_ST_IDLE = 2'b00,
    CAIO_ST_WORD = 2'b01,
    CAIO_ST_RMW  = 2'b10
  } caio_st_e;

  caio_st_e          st_q;
  logic [3:0]        op_q;
  logic [DW-1:0]     hold_hi_q;
  logic [DW-1:0]     hold_lo_q;
  logic              hold_c_q;
  logic [8:0]        hold_addr_q;
  logic [2:0]        hold_bit_q;
  logic [DW-1:0]     hold_rd_q;
  logic [7:0]        flags_q;
  logic [DW-1:0]     res_lo_q;
  logic [DW-1:0]     res_hi_q;
  logic              res_valid_q;
  logic              skip_q;
  logic              err_q;

  // -----------------------------------------------------------------------
  // Byte arithmetic
  // -----------------------------------------------------------------------
  logic              is_sub;
  logic              use_c;
  logic [DW:0]       sum;
  logic [4:0]        half;
  logic [DW-1:0]     logic_res;
  logic [DW-1:0]     b_eff;
  logic              cin;

  // Carry chain shared by add and subtract to keep one adder
  always_comb begin
    is_sub = (op_code_in == caio_pkg::CAIO_OP_SUB) ||
             (op_code_in == caio_pkg::CAIO_OP_SUBC);
    use_c  = (op_code_in == caio_pkg::CAIO_OP_ADC) ||
             (op_code_in == caio_pkg::CAIO_OP_SUBC);
    cin    = use_c & flags_q[caio_pkg::FLAG_C];
    b_eff  = is_sub ? ~op_b_in : op_b_in;
    if (is_sub) begin
      sum  = {1'b0, op_a_in} + {1'b0, b_eff} + {{DW{1'b0}}, ~cin};
      half = {1'b0, op_a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, ~cin};
    end else begin
      sum  = {1'b0, op_a_in} + {1'b0, b_eff} + {{DW{1'b0}}, cin};
      half = {1'b0, op_a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    end
    logic_res = (op_code_in == caio_pkg::CAIO_OP_AND) ?
                (op_a_in & op_b_in) : (op_a_in | op_b_in);
  end

  // -----------------------------------------------------------------------
  // Word arithmetic, second half of a two-cycle operation
  // -----------------------------------------------------------------------
  logic [2*DW-1:0]   wpair;
  logic [2*DW-1:0]   wres;
  logic              wsub;
  assign wpair = {hold_hi_q, hold_lo_q};
  assign wsub  = (op_q == caio_pkg::CAIO_OP_WSUB);
  assign wres  = wsub ? (wpair - {{(2*DW-6){1'b0}}, hold_addr_q[5:0]})
                      : (wpair + {{(2*DW-6){1'b0}}, hold_addr_q[5:0]});

  // Read-modify-write value: whole register rewritten, not just the bit.
  // Built from the byte caught at the take; the bus is idle by the write.
  logic [DW-1:0]     rmw_val;
  always_comb begin
    rmw_val = hold_rd_q;
    rmw_val[hold_bit_q] = (op_q == caio_pkg::CAIO_OP_BIT_SET);
  end

  // Address legality per access class
  logic              addr_ok;
  always_comb begin
    case (op_code_in)
      caio_pkg::CAIO_OP_BIT_SET,
      caio_pkg::CAIO_OP_BIT_CLR,
      caio_pkg::CAIO_OP_SKIP_S,
      caio_pkg::CAIO_OP_SKIP_C: addr_ok = in_bit_range(addr_in);
      caio_pkg::CAIO_OP_IO_IN,
      caio_pkg::CAIO_OP_IO_OUT: addr_ok = in_io_range(addr_in);
      default:                  addr_ok = 1'b1;
    endcase
  end

  // Busy during the second cycle of word ops and bit rewrites
  assign op_ready_out = (st_q == CAIO_ST_IDLE);
  logic take;
  assign take = op_valid_in & op_ready_out;

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q        <= CAIO_ST_IDLE;
      op_q        <= 4'h0;
      hold_hi_q   <= '0;
      hold_lo_q   <= '0;
      hold_c_q    <= 1'b0;
      hold_addr_q <= 9'h000;
      hold_bit_q  <= 3'h0;
      hold_rd_q   <= '0;
    end else begin
      case (st_q)
        CAIO_ST_IDLE: begin
          if (take) begin
            op_q        <= op_code_in;
            hold_hi_q   <= op_a_hi_in;
            hold_lo_q   <= op_a_in;
            hold_c_q    <= flags_q[caio_pkg::FLAG_C];
            hold_addr_q <= (op_code_in == caio_pkg::CAIO_OP_WADD ||
                            op_code_in == caio_pkg::CAIO_OP_WSUB) ?
                           {3'b000, word_imm_in} : addr_in;
            hold_bit_q  <= bit_sel_in;
            hold_rd_q   <= io_rdata_in;
            if (op_code_in == caio_pkg::CAIO_OP_WADD ||
                op_code_in == caio_pkg::CAIO_OP_WSUB) begin
              st_q <= CAIO_ST_WORD;
            end else if ((op_code_in == caio_pkg::CAIO_OP_BIT_SET ||
                          op_code_in == caio_pkg::CAIO_OP_BIT_CLR) &&
                         addr_ok) begin
              st_q <= CAIO_ST_RMW;
            end
          end
        end
        CAIO_ST_WORD: st_q <= CAIO_ST_IDLE;
        CAIO_ST_RMW:  st_q <= CAIO_ST_IDLE;
        default:      st_q <= CAIO_ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Results and flags
  // -----------------------------------------------------------------------
  // Flags not touched by an operation keep their previous value
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flags_q     <= caio_pkg::FLAGS_RESET;
      res_lo_q    <= '0;
      res_hi_q    <= '0;
      res_valid_q <= 1'b0;
      skip_q      <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      res_valid_q <= 1'b0;
      skip_q      <= 1'b0;
      err_q       <= 1'b0;
      if (st_q == CAIO_ST_WORD) begin
        res_lo_q    <= wres[DW-1:0];
        res_hi_q    <= wres[2*DW-1:DW];
        res_valid_q <= 1'b1;
        flags_q[caio_pkg::FLAG_Z] <= (wres == '0);
        flags_q[caio_pkg::FLAG_N] <= wres[2*DW-1];
        flags_q[caio_pkg::FLAG_V] <= wsub ? (hold_hi_q[DW-1] & ~wres[2*DW-1])
                                          : (~hold_hi_q[DW-1] & wres[2*DW-1]);
        flags_q[caio_pkg::FLAG_C] <= wsub ? (wres[2*DW-1] & ~hold_hi_q[DW-1])
                                          : (~wres[2*DW-1] & hold_hi_q[DW-1]);
        flags_q[caio_pkg::FLAG_S] <= wres[2*DW-1] ^
          (wsub ? (hold_hi_q[DW-1] & ~wres[2*DW-1])
                : (~hold_hi_q[DW-1] & wres[2*DW-1]));
      end else if (take) begin
        err_q <= ~addr_ok;
        case (op_code_in)
          caio_pkg::CAIO_OP_ADD, caio_pkg::CAIO_OP_ADC,
          caio_pkg::CAIO_OP_SUB, caio_pkg::CAIO_OP_SUBC: begin
            res_lo_q    <= sum[DW-1:0];
            res_valid_q <= 1'b1;
            flags_q[caio_pkg::FLAG_Z] <= (sum[DW-1:0] == '0);
            flags_q[caio_pkg::FLAG_N] <= sum[DW-1];
            flags_q[caio_pkg::FLAG_C] <= is_sub ? ~sum[DW] : sum[DW];
            flags_q[caio_pkg::FLAG_H] <= is_sub ? ~half[4] : half[4];
            flags_q[caio_pkg::FLAG_V] <= (op_a_in[DW-1] == b_eff[DW-1]) &&
                                         (sum[DW-1] != op_a_in[DW-1]);
          end
          caio_pkg::CAIO_OP_AND, caio_pkg::CAIO_OP_OR: begin
            res_lo_q    <= logic_res;
            res_valid_q <= 1'b1;
            flags_q[caio_pkg::FLAG_Z] <= (logic_res == '0);
            flags_q[caio_pkg::FLAG_N] <= logic_res[DW-1];
            flags_q[caio_pkg::FLAG_V] <= 1'b0;
          end
          caio_pkg::CAIO_OP_SKIP_S: begin
            skip_q <= addr_ok & io_rdata_in[bit_sel_in];
          end
          caio_pkg::CAIO_OP_SKIP_C: begin
            skip_q <= addr_ok & ~io_rdata_in[bit_sel_in];
          end
          caio_pkg::CAIO_OP_IO_IN, caio_pkg::CAIO_OP_LDST: begin
            // A store has no result; the last one keeps standing
            if (io_rd_out) begin
              res_lo_q    <= io_rdata_in;
              res_valid_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------------
  // Data-space access
  // -----------------------------------------------------------------------
  // Short I/O numbers are moved up by the data-space offset, so the
  // outside world only ever sees data-space addresses.
  logic [8:0] io_map;
  assign io_map = addr_in + caio_pkg::IO_DATA_OFS;

  always_comb begin
    io_rd_out    = 1'b0;
    io_wr_out    = 1'b0;
    io_addr_out  = io_map;
    io_wdata_out = op_b_in;
    if (st_q == CAIO_ST_RMW) begin
      io_addr_out  = hold_addr_q + caio_pkg::IO_DATA_OFS;
      io_wr_out    = 1'b1;
      io_wdata_out = rmw_val;
    end else if (take && addr_ok) begin
      case (op_code_in)
        caio_pkg::CAIO_OP_IO_IN,
        caio_pkg::CAIO_OP_SKIP_S,
        caio_pkg::CAIO_OP_SKIP_C,
        caio_pkg::CAIO_OP_BIT_SET,
        caio_pkg::CAIO_OP_BIT_CLR: io_rd_out = 1'b1;
        caio_pkg::CAIO_OP_IO_OUT:  io_wr_out = 1'b1;
        caio_pkg::CAIO_OP_LDST: begin
          // Raw data-space address, extended range only reachable here
          io_addr_out = addr_in;
          io_rd_out   = ~word_imm_in[0];
          io_wr_out   = word_imm_in[0];
        end
        default: ;
      endcase
    end
  end

  assign res_valid_out = res_valid_q;
  assign res_lo_out    = res_lo_q;
  assign res_hi_out    = res_hi_q;
  assign flags_out     = flags_q;
  assign skip_out      = skip_q;
  assign addr_err_out  = err_q;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  a_word_two_cycles: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && (op_code_in == caio_pkg::CAIO_OP_WADD) |=> !op_ready_out ##1
    res_valid_out) else $error("word add not two cycles");
  a_word_sub_busy: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && (op_code_in == caio_pkg::CAIO_OP_WSUB) |=> !res_valid_out ##1
    (res_valid_out && op_ready_out)) else $error("word sub timing");
  a_add_one_cycle: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && (op_code_in == caio_pkg::CAIO_OP_ADD) |=>
    res_valid_out && (res_lo_out == $past(op_a_in) + $past(op_b_in)))
    else $error("byte add wrong");
  a_sub_result: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && (op_code_in == caio_pkg::CAIO_OP_SUB) |=>
    (res_lo_out == $past(op_a_in) - $past(op_b_in)) &&
    (flags_out[caio_pkg::FLAG_C] == ($past(op_a_in) < $past(op_b_in))))
    else $error("byte sub wrong");
  a_logic_keeps_c: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && (op_code_in == caio_pkg::CAIO_OP_AND) |=>
    $stable(flags_out[caio_pkg::FLAG_C]) && !flags_out[caio_pkg::FLAG_V])
    else $error("and touched carry");
  a_or_keeps_h: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && (op_code_in == caio_pkg::CAIO_OP_OR) |=>
    $stable(flags_out[caio_pkg::FLAG_H]) &&
    (res_lo_out == ($past(op_a_in) | $past(op_b_in))))
    else $error("or wrong");
  a_bit_range_only: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    io_wr_out && (st_q == CAIO_ST_RMW) |-> io_addr_out <= caio_pkg::IO_LAST)
    else $error("bit op outside range");
  a_rmw_follows_rd: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && io_rd_out && (op_code_in == caio_pkg::CAIO_OP_BIT_CLR) |=>
    io_wr_out && (io_addr_out == $past(io_addr_out)))
    else $error("bit clear not rewritten");
  a_short_io_map: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && (op_code_in == caio_pkg::CAIO_OP_IO_OUT) && addr_ok |->
    io_wr_out && (io_addr_out == addr_in + caio_pkg::IO_DATA_OFS))
    else $error("io offset wrong");
  a_no_ext_short: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && (op_code_in == caio_pkg::CAIO_OP_IO_IN) &&
    (addr_in >= caio_pkg::EXT_IO_FIRST) |-> !io_rd_out ##1 addr_err_out)
    else $error("extended io reached by short op");

  a_store_no_result: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    take && (op_code_in == caio_pkg::CAIO_OP_LDST) && word_imm_in[0] |=>
    !res_valid_out) else $error("store gave a result");

endmodule : caio_alu

// ---- tb/caio_io_model.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------------
// I/O and data space seen by the datapath
// ---------------------------------------------------------------------
module caio_io_model #(
  parameter logic [8:0] W1C_ADDR = 9'h025,
  parameter logic [7:0] W1C_MASK = 8'h80
) (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       io_rd_in,
  input  wire logic       io_wr_in,
  input  wire logic [8:0] io_addr_in,
  input  wire logic [7:0] io_wdata_in,
  output logic      [7:0] io_rdata_out
);
  logic [7:0] mem [512];
  logic [7:0] last_q;

  // Storage; one flag clears on a written one, so a blind write-back hurts
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 512; i++) begin
        mem[i] <= 8'h00;
      end
      mem[W1C_ADDR] <= W1C_MASK;
    end else if (io_wr_in) begin
      if (io_addr_in == W1C_ADDR) begin
        mem[io_addr_in] <= (mem[io_addr_in] & W1C_MASK & ~io_wdata_in) |
                           (io_wdata_in & ~W1C_MASK);
      end else begin
        mem[io_addr_in] <= io_wdata_in;
      end
    end
  end

  // Last value read, kept so an idle bus shows something else
  always_ff @(posedge clk_in) begin
    if (io_rd_in) begin
      last_q <= mem[io_addr_in];
    end
  end

  // Idle bus shows the inverse, not a friendly stale value
  assign io_rdata_out = io_rd_in ? mem[io_addr_in] : ~last_q;
endmodule : caio_io_model

// ---- tb/test_caio_alu.sv ----
`timescale 1ns/1ns
module test_caio_alu;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic clk_in, sys_rst_in, op_valid, rv, sk, er;
  logic [3:0] op_code;
  logic [7:0] op_a, op_b, op_a_hi, lo, hi, fl, ef, rdata;
  logic [5:0] word_imm;
  logic [8:0] addr;
  logic [2:0] bit_sel;
  logic ready, res_valid, skip, io_rd, io_wr, addr_err;
  logic [7:0] res_lo, res_hi, flags, io_wdata;
  logic [8:0] io_addr;
  int errors, tests_run;

  caio_alu DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .op_valid_in(op_valid), .op_code_in(op_code), .op_a_in(op_a),
    .op_b_in(op_b), .op_a_hi_in(op_a_hi), .word_imm_in(word_imm),
    .addr_in(addr), .bit_sel_in(bit_sel), .io_rdata_in(rdata),
    .op_ready_out(ready), .res_valid_out(res_valid), .res_lo_out(res_lo),
    .res_hi_out(res_hi), .flags_out(flags), .skip_out(skip),
    .io_rd_out(io_rd), .io_wr_out(io_wr), .io_addr_out(io_addr),
    .io_wdata_out(io_wdata), .addr_err_out(addr_err));

  caio_io_model u_io (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .io_rd_in(io_rd), .io_wr_in(io_wr), .io_addr_in(io_addr),
    .io_wdata_in(io_wdata), .io_rdata_out(rdata));

  // ---------------------------------------------------------------------
  // Compare and closing tasks
  // ---------------------------------------------------------------------
  task automatic chk_val(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic conclude();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------------
  // Access tasks; snapshot taken where the answer stands
  // ---------------------------------------------------------------------
  task automatic issue(input logic [3:0] code, input logic [7:0] a,
    input logic [7:0] b, input logic [7:0] ah, input logic [5:0] imm,
    input logic [8:0] ad, input logic [2:0] bs, input int lat);
    @(posedge clk_in);
    op_valid <= 1'b1;
    op_code  <= code;
    op_a     <= a;
    op_b     <= b;
    op_a_hi  <= ah;
    word_imm <= imm;
    addr     <= ad;
    bit_sel  <= bs;
    @(posedge clk_in);
    op_valid <= 1'b0;
    repeat (lat - 1) @(posedge clk_in);
    #1;
    {rv, lo, hi, fl, sk, er} = {res_valid, res_lo, res_hi, flags, skip,
                                addr_err};
  endtask : issue

  // Byte op with expected result and flag byte worked out here
  task automatic byte_op(input logic [3:0] code, input logic [7:0] a,
                         input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic       ci;
    ci = (code == caio_pkg::CAIO_OP_ADC || code == caio_pkg::CAIO_OP_SUBC) ?
         ef[caio_pkg::FLAG_C] : 1'b0;
    h = 5'h00;
    if (code == caio_pkg::CAIO_OP_ADD || code == caio_pkg::CAIO_OP_ADC) begin
      s = {1'b0, a} + b + ci;
      h = {1'b0, a[3:0]} + b[3:0] + ci;
      ef[caio_pkg::FLAG_V] = (a[7] == b[7]) && (s[7] != a[7]);
    end else if (code == caio_pkg::CAIO_OP_AND) begin
      s = {1'b0, a & b};
      ef[caio_pkg::FLAG_V] = 1'b0;
    end else if (code == caio_pkg::CAIO_OP_OR) begin
      s = {1'b0, a | b};
      ef[caio_pkg::FLAG_V] = 1'b0;
    end else begin
      s = {1'b0, a} - b - ci;
      h = {1'b0, a[3:0]} - b[3:0] - ci;
      ef[caio_pkg::FLAG_V] = (a[7] != b[7]) && (s[7] != a[7]);
    end
    if (code != caio_pkg::CAIO_OP_AND && code != caio_pkg::CAIO_OP_OR) begin
      ef[caio_pkg::FLAG_C] = s[8];
      ef[caio_pkg::FLAG_H] = h[4];
    end
    ef[caio_pkg::FLAG_Z] = (s[7:0] == 8'h00);
    ef[caio_pkg::FLAG_N] = s[7];
    issue(code, a, b, 8'h00, 6'h00, 9'h000, 3'h0, 1);
    chk_bit("byte valid", 1'b1, rv);
    chk_val("byte result", {8'h00, s[7:0]}, {8'h00, lo});
    chk_val("byte flags", {8'h00, ef}, {8'h00, fl});
  endtask : byte_op

  // Word op: answer must stand two cycles after the take
  task automatic word_op(input logic [3:0] code, input logic [15:0] w,
                         input logic [5:0] k);
    logic [16:0] s;
    s = (code == caio_pkg::CAIO_OP_WADD) ? {1'b0, w} + k : {1'b0, w} - k;
    ef[caio_pkg::FLAG_C] = s[16];
    ef[caio_pkg::FLAG_V] = (code == caio_pkg::CAIO_OP_WADD) ?
                           (~w[15] & s[15]) : (w[15] & ~s[15]);
    ef[caio_pkg::FLAG_N] = s[15];
    ef[caio_pkg::FLAG_S] = s[15] ^ ef[caio_pkg::FLAG_V];
    ef[caio_pkg::FLAG_Z] = (s[15:0] == 16'h0000);
    issue(code, w[7:0], 8'h00, w[15:8], k, 9'h000, 3'h0, 2);
    chk_bit("word valid", 1'b1, rv);
    chk_val("word result", s[15:0], {hi, lo});
    chk_val("word flags", {8'h00, ef}, {8'h00, fl});
  endtask : word_op

  task automatic io_op(input logic [3:0] code, input logic [8:0] ad,
    input logic [7:0] b, input logic [5:0] imm, input logic [2:0] bs);
    issue(code, 8'h00, b, 8'h00, imm, ad, bs, 1);
  endtask : io_op

  // ---------------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Whole sequence needs about a hundred cycles
  initial begin
    repeat (4000) @(posedge clk_in);
    errors++;
    conclude();
  end

  initial begin
    {op_valid, op_code, op_a, op_b, op_a_hi} = '0;
    {word_imm, addr, bit_sel, errors, tests_run} = '0;
    sys_rst_in = 1'b1;
    ef = caio_pkg::FLAGS_RESET;
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1;
    chk_val("reset flags", {8'h00, ef}, {8'h00, flags});
    chk_bit("reset ready", 1'b1, ready);
    byte_op(caio_pkg::CAIO_OP_ADD, 8'h7F, 8'h01);
    byte_op(caio_pkg::CAIO_OP_ADD, 8'hFF, 8'h01);
    byte_op(caio_pkg::CAIO_OP_AND, 8'hF0, 8'h8F);
    byte_op(caio_pkg::CAIO_OP_ADC, 8'h0F, 8'h10);
    byte_op(caio_pkg::CAIO_OP_SUB, 8'h00, 8'h01);
    byte_op(caio_pkg::CAIO_OP_OR, 8'h00, 8'h00);
    byte_op(caio_pkg::CAIO_OP_SUBC, 8'h80, 8'h00);
    byte_op(caio_pkg::CAIO_OP_SUB, 8'h42, 8'h42);
    byte_op(caio_pkg::CAIO_OP_OR, 8'h81, 8'h10);
    word_op(caio_pkg::CAIO_OP_WADD, 16'hFFFF, 6'h01);
    word_op(caio_pkg::CAIO_OP_WADD, 16'h7FC1, 6'h3F);
    word_op(caio_pkg::CAIO_OP_WSUB, 16'h0000, 6'h01);
    word_op(caio_pkg::CAIO_OP_WSUB, 16'h8000, 6'h01);
    // Read-modify-write must clear the pending flag
    io_op(caio_pkg::CAIO_OP_BIT_SET, 9'h005, 8'h00, 6'h00, 3'h0);
    io_op(caio_pkg::CAIO_OP_IO_IN, 9'h005, 8'h00, 6'h00, 3'h0);
    chk_val("flag cleared", 16'h0001, {8'h00, lo});
    // Short numbers map into data space with the offset
    io_op(caio_pkg::CAIO_OP_IO_OUT, 9'h006, 8'h5A, 6'h00, 3'h0);
    io_op(caio_pkg::CAIO_OP_LDST, 9'h026, 8'h00, 6'h00, 3'h0);
    chk_val("io in data space", 16'h005A, {8'h00, lo});
    io_op(caio_pkg::CAIO_OP_LDST, 9'h05F, 8'h3C, 6'h01, 3'h0);
    chk_bit("store no result", 1'b0, rv);
    io_op(caio_pkg::CAIO_OP_IO_IN, 9'h03F, 8'h00, 6'h00, 3'h0);
    chk_val("last io number", 16'h003C, {8'h00, lo});
    io_op(caio_pkg::CAIO_OP_LDST, 9'h1FF, 8'hC3, 6'h01, 3'h0);
    io_op(caio_pkg::CAIO_OP_LDST, 9'h1FF, 8'h00, 6'h00, 3'h0);
    chk_val("extended io", 16'h00C3, {8'h00, lo});
    // Out-of-range short accesses are dropped
    io_op(caio_pkg::CAIO_OP_IO_OUT, 9'h040, 8'h77, 6'h00, 3'h0);
    chk_bit("io out refused", 1'b1, er);
    io_op(caio_pkg::CAIO_OP_IO_IN, 9'h040, 8'h00, 6'h00, 3'h0);
    chk_bit("io in refused", 1'b1, er);
    chk_bit("io in no result", 1'b0, rv);
    io_op(caio_pkg::CAIO_OP_IO_IN, 9'h060, 8'h00, 6'h00, 3'h0);
    chk_bit("ext io in refused", 1'b1, er);
    chk_bit("ext io in no result", 1'b0, rv);
    io_op(caio_pkg::CAIO_OP_LDST, 9'h060, 8'h00, 6'h00, 3'h0);
    chk_val("extended untouched", 16'h0000, {8'h00, lo});
    // Bit ops at the top of the bit range, then one past it
    io_op(caio_pkg::CAIO_OP_IO_OUT, 9'h01F, 8'h00, 6'h00, 3'h0);
    io_op(caio_pkg::CAIO_OP_BIT_SET, 9'h01F, 8'h00, 6'h00, 3'h7);
    io_op(caio_pkg::CAIO_OP_IO_IN, 9'h01F, 8'h00, 6'h00, 3'h0);
    chk_val("bit set", 16'h0080, {8'h00, lo});
    io_op(caio_pkg::CAIO_OP_BIT_CLR, 9'h01F, 8'h00, 6'h00, 3'h7);
    io_op(caio_pkg::CAIO_OP_IO_IN, 9'h01F, 8'h00, 6'h00, 3'h0);
    chk_val("bit clear", 16'h0000, {8'h00, lo});
    io_op(caio_pkg::CAIO_OP_BIT_SET, 9'h020, 8'h00, 6'h00, 3'h0);
    chk_bit("bit op refused", 1'b1, er);
    io_op(caio_pkg::CAIO_OP_LDST, 9'h040, 8'h00, 6'h00, 3'h0);
    chk_val("refused no write", 16'h0000, {8'h00, lo});
    // Both skip forms on both bit values
    for (int v = 0; v < 2; v++) begin
      io_op(caio_pkg::CAIO_OP_IO_OUT, 9'h01F, v ? 8'h08 : 8'hF7, 6'h00, 3'h0);
      io_op(caio_pkg::CAIO_OP_SKIP_S, 9'h01F, 8'h00, 6'h00, 3'h3);
      chk_bit("skip if set", v[0], sk);
      io_op(caio_pkg::CAIO_OP_SKIP_C, 9'h01F, 8'h00, 6'h00, 3'h3);
      chk_bit("skip if clear", ~v[0], sk);
    end
    io_op(caio_pkg::CAIO_OP_SKIP_S, 9'h020, 8'h00, 6'h00, 3'h3);
    chk_bit("skip refused", 1'b1, er);
    chk_bit("skip refused none", 1'b0, sk);
    conclude();
  end
endmodule : test_caio_alu
